// *** flash_model.sv ***
// Purpose: Behavioural program Flash array behind the table access unit
// Assumes: Read request is a level held until the answer has been seen
// Notes: Data mixes all address bits, so a wrong pointer bit shows up
module flash_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic mem_rd_req,
    input wire logic [21:0] mem_addr,
    output logic [7:0] mem_rd_data,
    output logic mem_rd_valid,
    input wire logic block_write_start,
    input wire logic erase_start,
    output logic flash_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] wait_cnt; // Cycles spent on the current read
    logic slow; // Alternates prompt and slow answers
    logic [4:0] busy_cnt; // Remaining array busy time
    // Read answer; data bus churns outside the answer cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt <= 3'h0;
            slow <= 1'b0;
            mem_rd_valid <= 1'b0;
            mem_rd_data <= 8'h00;
        end else if (mem_rd_req && !mem_rd_valid && wait_cnt == (slow ? 3'h3 : 3'h0)) begin
            mem_rd_valid <= 1'b1;
            mem_rd_data <= mem_addr[7:0] ^ mem_addr[15:8] ^ {mem_addr[21:16], 2'h0};
            wait_cnt <= 3'h0;
            slow <= !slow;
        end else begin
            mem_rd_valid <= 1'b0;
            mem_rd_data <= ~mem_rd_data;
            wait_cnt <= (mem_rd_req && !mem_rd_valid) ? wait_cnt + 3'h1 : 3'h0;
        end
    end
    // Array stays busy for a while after any timed write or erase
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            busy_cnt <= 5'h00;
        end else if (block_write_start || erase_start) begin
            busy_cnt <= 5'h14;
        end else if (busy_cnt != 5'h00) begin
            busy_cnt <= busy_cnt - 5'h01;
        end
    end
    assign flash_busy = (busy_cnt != 5'h00);
endmodule : flash_model

// *** table_access_pkg.sv ***
// Purpose: Shared constants and types for the table pointer access unit
// Assumes: One system clock, register file on a classic Wishbone slave
// Notes: Register offsets are byte addresses of aligned 32-bit words
package table_access_pkg;
    // Pointer geometry
    localparam int PTR_W = 22; // Full byte pointer width
    localparam int LOW_W = 21; // Program space part of the pointer
    localparam int HOLD_W = 5; // Holding register index width
    localparam int ROW_LSB = 6; // First bit of the block selector
    localparam int ROW_W = 16; // Block selector width
    localparam int ADR_W = 8; // Bus address width

    // Register offsets
    localparam logic [7:0] OFF_LATCH = 8'h00;
    localparam logic [7:0] OFF_PTR_U = 8'h04;
    localparam logic [7:0] OFF_PTR_H = 8'h08;
    localparam logic [7:0] OFF_PTR_L = 8'h0c;
    localparam logic [7:0] OFF_CTRL = 8'h10;
    localparam logic [7:0] OFF_STAT = 8'h14;

    // Field positions
    localparam int CTRL_WRITE_BIT = 0; // Start timed block write
    localparam int CTRL_ERASE_BIT = 1; // Start block erase
    localparam int STAT_BUSY_BIT = 0; // Table read in flight
    localparam int STAT_FLASH_BIT = 1; // Flash array busy
    localparam int STAT_CFG_BIT = 2; // Pointer selects configuration space

    // Values after reset
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [21:0] PTR_RST = 22'h000000;

    // Pointer update variants
    typedef enum logic [1:0] {
        MODE_KEEP = 2'h0,
        MODE_POST_INC = 2'h1,
        MODE_POST_DEC = 2'h2,
        MODE_PRE_INC = 2'h3
    } ptr_mode_t;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_READ = 2'b10
    } state_t;
endpackage : table_access_pkg

// *** table_pointer_access.sv ***
// Purpose: Byte mover between program Flash and data RAM via a pointer
// Assumes: Decoder holds off new operations while op_busy is high
// Notes: Registers sit on a classic Wishbone slave, answer one cycle late
module table_pointer_access (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic op_valid,
    input wire logic op_is_write,
    input wire logic [1:0] op_mode,
    output logic op_busy,
    output logic op_done,
    output logic mem_rd_req,
    output logic [21:0] mem_addr,
    input wire logic [7:0] mem_rd_data,
    input wire logic mem_rd_valid,
    output logic hold_wr_en,
    output logic [4:0] hold_wr_index,
    output logic [7:0] hold_wr_data,
    output logic block_write_start,
    output logic erase_start,
    output logic [15:0] block_row,
    input wire logic flash_busy
);
    // Byte carried between Flash and RAM
    logic [7:0] table_transfer_latch;
    // Joined upper, high and low pointer bytes
    logic [21:0] program_byte_pointer;
    // Sequencer state
    table_access_pkg::state_t state;
    // Update variant of the operation in flight
    table_access_pkg::ptr_mode_t mode_q;
    // Access address chosen when the operation is taken
    logic [21:0] next_access;
    // Operation taken this cycle
    logic op_take;
    // Bus strobes, only in the cycle before the acknowledge
    logic bus_req;
    logic bus_wr;
    logic bus_rd;

    // Step the program space part, keeping the space select bit
    function automatic logic [21:0] bump(input logic [21:0] p, input logic down);
        logic [20:0] low;
        low = down ? p[20:0] - 21'h000001 : p[20:0] + 21'h000001;
        return {p[21], low};
    endfunction : bump

    // Pointer value left behind once the access is over
    function automatic logic [21:0] after_access(input logic [21:0] a,
                                                 input table_access_pkg::ptr_mode_t m);
        case (m)
            table_access_pkg::MODE_POST_INC: after_access = bump(a, 1'b0);
            table_access_pkg::MODE_POST_DEC: after_access = bump(a, 1'b1);
            default: after_access = a; // Keep, or already bumped before access
        endcase
    endfunction : after_access

    assign bus_req = wb_cyc && wb_stb && !wb_ack;
    assign bus_wr = bus_req && wb_we && wb_sel[0];
    assign bus_rd = bus_req && !wb_we;
    assign op_take = (state == table_access_pkg::ST_IDLE) && op_valid;

    // Pre-increment moves the pointer before it is used
    always_comb begin
        if (table_access_pkg::ptr_mode_t'(op_mode) == table_access_pkg::MODE_PRE_INC) begin
            next_access = bump(program_byte_pointer, 1'b0);
        end else begin
            next_access = program_byte_pointer;
        end
    end

    // Wishbone acknowledge, one cycle pulse per request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack <= 1'b0;
        end else begin
            wb_ack <= bus_req;
        end
    end

    // Read data mux, unmapped offsets read as zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wb_dat_r <= 32'h00000000;
        end else if (bus_rd) begin
            case (wb_adr)
                table_access_pkg::OFF_LATCH: wb_dat_r <= {24'h000000, table_transfer_latch};
                table_access_pkg::OFF_PTR_U: wb_dat_r <= {26'h0000000, program_byte_pointer[21:16]};
                table_access_pkg::OFF_PTR_H: wb_dat_r <= {24'h000000, program_byte_pointer[15:8]};
                table_access_pkg::OFF_PTR_L: wb_dat_r <= {24'h000000, program_byte_pointer[7:0]};
                table_access_pkg::OFF_STAT: begin
                    wb_dat_r <= 32'h00000000;
                    wb_dat_r[table_access_pkg::STAT_BUSY_BIT] <= op_busy;
                    wb_dat_r[table_access_pkg::STAT_FLASH_BIT] <= flash_busy;
                    wb_dat_r[table_access_pkg::STAT_CFG_BIT] <= program_byte_pointer[21];
                end
                default: wb_dat_r <= 32'h00000000; // Control reads zero too
            endcase
        end
    end

    // Sequencer; writes finish in one cycle, reads wait for the array
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state <= table_access_pkg::ST_IDLE;
            mode_q <= table_access_pkg::MODE_KEEP;
            op_busy <= 1'b0;
            op_done <= 1'b0;
            mem_rd_req <= 1'b0;
            mem_addr <= table_access_pkg::PTR_RST;
        end else begin
            op_done <= 1'b0;
            case (state)
                table_access_pkg::ST_IDLE: begin
                    if (op_take) begin
                        mode_q <= table_access_pkg::ptr_mode_t'(op_mode);
                        mem_addr <= next_access;
                        if (op_is_write) begin
                            op_done <= 1'b1;
                        end else begin
                            mem_rd_req <= 1'b1;
                            op_busy <= 1'b1;
                            state <= table_access_pkg::ST_READ;
                        end
                    end
                end
                table_access_pkg::ST_READ: begin
                    // Request held until the array answers
                    if (mem_rd_valid) begin
                        mem_rd_req <= 1'b0;
                        op_busy <= 1'b0;
                        op_done <= 1'b1;
                        state <= table_access_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= table_access_pkg::ST_IDLE;
                    op_busy <= 1'b0;
                    mem_rd_req <= 1'b0;
                end
            endcase
        end
    end

    // Holding register write strobe with latch byte
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            hold_wr_en <= 1'b0;
            hold_wr_index <= 5'h00;
            hold_wr_data <= 8'h00;
        end else begin
            hold_wr_en <= op_take && op_is_write;
            if (op_take && op_is_write) begin
                hold_wr_index <= next_access[4:0];
                hold_wr_data <= table_transfer_latch;
            end
        end
    end

    // Transfer latch; an arriving Flash byte beats a bus write
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            table_transfer_latch <= table_access_pkg::LATCH_RST;
        end else if (state == table_access_pkg::ST_READ && mem_rd_valid) begin
            table_transfer_latch <= mem_rd_data;
        end else if (bus_wr && wb_adr == table_access_pkg::OFF_LATCH) begin
            table_transfer_latch <= wb_dat_w[7:0];
        end
    end

    // Pointer; a software byte write overrides the hardware update
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            program_byte_pointer <= table_access_pkg::PTR_RST;
        end else begin
            if (op_take && op_is_write) begin
                program_byte_pointer <= after_access(next_access,
                                                     table_access_pkg::ptr_mode_t'(op_mode));
            end else if (op_take) begin
                program_byte_pointer <= next_access; // Pre-increment shows at once
            end else if (state == table_access_pkg::ST_READ && mem_rd_valid) begin
                program_byte_pointer <= after_access(mem_addr, mode_q);
            end
            if (bus_wr) begin
                case (wb_adr)
                    table_access_pkg::OFF_PTR_U: program_byte_pointer[21:16] <= wb_dat_w[5:0];
                    table_access_pkg::OFF_PTR_H: program_byte_pointer[15:8] <= wb_dat_w[7:0];
                    table_access_pkg::OFF_PTR_L: program_byte_pointer[7:0] <= wb_dat_w[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // Block write and erase starts; refused while the array is busy
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            block_write_start <= 1'b0;
            erase_start <= 1'b0;
            block_row <= 16'h0000;
        end else begin
            block_write_start <= 1'b0;
            erase_start <= 1'b0;
            if (bus_wr && wb_adr == table_access_pkg::OFF_CTRL && !flash_busy) begin
                // Erase wins if both are asked at once
                if (wb_dat_w[table_access_pkg::CTRL_ERASE_BIT]) begin
                    erase_start <= 1'b1;
                    block_row <= program_byte_pointer[21:6];
                end else if (wb_dat_w[table_access_pkg::CTRL_WRITE_BIT]) begin
                    block_write_start <= 1'b1;
                    block_row <= program_byte_pointer[21:6];
                end
            end
        end
    end

    // Acknowledge is a single cycle
    ack_single_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wb_ack |=> !wb_ack) else $error("ack held two cycles");

    // Read address is the whole pointer
    read_full_addr_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_take && !op_is_write && op_mode == 2'h0 |=> mem_rd_req && mem_addr == $past(program_byte_pointer))
        else $error("read address not the pointer");

    // Arriving byte lands in the latch
    latch_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        state == table_access_pkg::ST_READ && mem_rd_valid |=> op_done && table_transfer_latch == $past(mem_rd_data))
        else $error("latch missed read byte");

    // Holding index from pointer low bits
    hold_index_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_take && op_is_write && op_mode == 2'h0 |=> hold_wr_en && hold_wr_index == $past(program_byte_pointer[4:0]) && hold_wr_data == $past(table_transfer_latch))
        else $error("holding write wrong");

    // Block row for a timed write
    write_row_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        block_write_start && !$past(op_take) && !$past(state == table_access_pkg::ST_READ) |-> block_row == program_byte_pointer[21:6])
        else $error("write row wrong");

    // Block row for an erase
    erase_row_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        erase_start && !$past(op_take) && !$past(state == table_access_pkg::ST_READ) |-> block_row == program_byte_pointer[21:6] && !block_write_start)
        else $error("erase row wrong");

    // Pre-increment steps the access address
    pre_inc_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_take && op_mode == 2'h3 |=> mem_addr[21] == $past(program_byte_pointer[21]) && mem_addr[20:0] == $past(program_byte_pointer[20:0]) + 21'h000001)
        else $error("pre-increment wrong");

    // Post-increment after a finished read
    post_inc_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_done && mode_q == table_access_pkg::MODE_POST_INC && !$past(bus_wr) |-> program_byte_pointer[20:0] == mem_addr[20:0] + 21'h000001)
        else $error("post-increment wrong");

    // Space select bit survives pointer updates
    cfg_bit_kept_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_done && !$past(bus_wr) |-> program_byte_pointer[21] == mem_addr[21] && $stable(program_byte_pointer[21]))
        else $error("space select bit changed");

    // Busy exactly while a read waits
    busy_tracks_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_busy == (state == table_access_pkg::ST_READ) && op_busy == mem_rd_req)
        else $error("busy out of step");

    // Software byte write lands in the pointer
    ptr_low_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        bus_wr && wb_adr == table_access_pkg::OFF_PTR_L |=>
        program_byte_pointer[7:0] == $past(wb_dat_w[7:0]))
        else $error("pointer low byte not written");

    // Keep mode leaves the pointer at the access address
    keep_mode_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_done && mode_q == table_access_pkg::MODE_KEEP && !$past(bus_wr) |->
        program_byte_pointer == mem_addr)
        else $error("keep mode moved pointer");

    // Post-decrement wraps inside the low 21 bits
    post_dec_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        op_done && mode_q == table_access_pkg::MODE_POST_DEC && !$past(bus_wr) |->
        program_byte_pointer[20:0] == mem_addr[20:0] - 21'h000001)
        else $error("post-decrement wrong");

    // No block start while the array is still busy
    start_refused_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        flash_busy |=> !block_write_start && !erase_start)
        else $error("start taken while array busy");
endmodule : table_pointer_access

// *** table_pointer_access_tb.sv ***
// Purpose: Self-checking bench for the table pointer access unit
// Assumes: Flash model answers reads and reports array busy
// Notes: Drivers queue expected results; one monitor compares them
module table_pointer_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, arst_n = 1'b0; // Clock and reset
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack; // Bus control
    logic [7:0] wb_adr = 8'h00; // Bus address
    logic [3:0] wb_sel = 4'h0; // Byte enables
    logic [31:0] wb_dat_w = 32'h0, wb_dat_r; // Bus data
    logic op_valid = 1'b0, op_is_write = 1'b0, op_busy, op_done; // Decoder side
    logic [1:0] op_mode = 2'h0; // Pointer update variant
    logic mem_rd_req, mem_rd_valid, hold_wr_en, block_write_start, erase_start, flash_busy;
    logic [21:0] mem_addr; // Flash access address
    logic [7:0] mem_rd_data, hold_wr_data, latch; // Flash byte, holding byte, model latch
    logic [4:0] hold_wr_index; // Holding slot
    logic [15:0] block_row; // Block selector
    logic [21:0] ptr; // Model pointer
    logic [31:0] rnd = 32'h5e8446da; // Random state
    logic [31:0] rd_q[$], hold_q[$], start_q[$]; // Expected results
    int error_cnt = 0, n_tests = 0; // Counters
    logic [31:0] hold_seen, start_seen; // Packed results for the monitor
    assign hold_seen = {19'h0, hold_wr_index, hold_wr_data};
    assign start_seen = {14'h0, block_write_start, erase_start, block_row};
    table_pointer_access u_dut (.clk_sys, .arst_n, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel,
        .wb_dat_w, .wb_dat_r, .wb_ack, .op_valid, .op_is_write, .op_mode, .op_busy, .op_done,
        .mem_rd_req, .mem_addr, .mem_rd_data, .mem_rd_valid, .hold_wr_en, .hold_wr_index,
        .hold_wr_data, .block_write_start, .erase_start, .block_row, .flash_busy);
    flash_model u_flash (.clk_sys, .arst_n, .mem_rd_req, .mem_addr, .mem_rd_data,
        .mem_rd_valid, .block_write_start, .erase_start, .flash_busy);
    always #4 clk_sys = ~clk_sys;
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    // Byte the Flash model holds at an address
    function automatic logic [7:0] fdata(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ {a[21:16], 2'h0};
    endfunction : fdata
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // One compare task for each kind of result
    task automatic check_read(input logic [31:0] exp, input logic [31:0] got);
        check("read data", exp, got);
    endtask : check_read
    task automatic check_hold(input logic [31:0] exp, input logic [31:0] got);
        check("holding write", exp, got);
    endtask : check_hold
    task automatic check_start(input logic [31:0] exp, input logic [31:0] got);
        check("flash start", exp, got);
    endtask : check_start
    task automatic check_addr(input logic [31:0] exp, input logic [31:0] got);
        check("mem_addr", exp, got);
    endtask : check_addr
    task automatic check_busy(input logic [31:0] exp, input logic [31:0] got);
        check("read in flight", exp, got);
    endtask : check_busy
    // Classic single cycle; holds the request until ack is sampled
    task automatic bus(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int i;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat_w <= dat;
        wb_sel <= 4'hf;
        for (i = 0; i < 20 && wb_ack !== 1'b1; i++) @(posedge clk_sys);
        if (wb_ack !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        bus(1'b0, adr, 32'h0);
    endtask : rd
    // Pointer bytes and latch read back against the model
    task automatic check_regs();
        rd(8'h04, {26'h0, ptr[21:16]});
        rd(8'h08, {24'h0, ptr[15:8]});
        rd(8'h0c, {24'h0, ptr[7:0]});
        rd(8'h00, {24'h0, latch});
    endtask : check_regs
    // One decoder operation; the model pointer moves as the variant says
    task automatic op(input logic wr, input logic [1:0] mode);
        int i;
        logic [21:0] a;
        if (mode == 2'h3) ptr = {ptr[21], ptr[20:0] + 21'h1};
        a = ptr;
        if (mode == 2'h1) ptr = {ptr[21], ptr[20:0] + 21'h1};
        if (mode == 2'h2) ptr = {ptr[21], ptr[20:0] - 21'h1};
        if (wr) hold_q.push_back({19'h0, a[4:0], latch});
        else latch = fdata(a);
        op_valid <= 1'b1;
        op_is_write <= wr;
        op_mode <= mode;
        @(posedge clk_sys);
        op_valid <= 1'b0;
        for (i = 0; i < 20 && op_done !== 1'b1; i++) @(posedge clk_sys);
        if (op_done !== 1'b1) begin
            error_cnt++;
            report_and_stop();
        end
        if (!wr) check_addr({10'h0, a}, {10'h0, mem_addr});
        check_regs();
    endtask : op
    // Monitor: each result that appears takes the oldest note
    always @(posedge clk_sys) begin
        if (wb_ack === 1'b1 && wb_cyc === 1'b1 && wb_we === 1'b0) begin
            if (rd_q.size() != 0) check_read(rd_q.pop_front(), wb_dat_r);
            else check("extra read", 32'h0, 32'h1);
        end
        if (hold_wr_en === 1'b1) begin
            if (hold_q.size() != 0) check_hold(hold_q.pop_front(), hold_seen);
            else check("extra holding write", 32'h0, 32'h1);
        end
        if (block_write_start === 1'b1 || erase_start === 1'b1) begin
            if (start_q.size() != 0) check_start(start_q.pop_front(), start_seen);
            else check("refused start", 32'h0, 32'h1);
        end
        // Flash answers only while the unit still waits for it
        if (mem_rd_valid === 1'b1) check_busy(32'h3, {30'h0, op_busy, mem_rd_req});
    end
    initial begin
        int n;
        int m;
        logic [1:0] c;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        ptr = 22'h0;
        latch = 8'h00;
        @(posedge clk_sys);
        check_regs();
        rd(8'h14, 32'h0);
        rd(8'h20, 32'h0); // Unmapped offset reads zero
        for (n = 0; n < 6; n++) begin
            rnd = lfsr(rnd);
            // First two passes sit at the wrap point of the low 21 bits
            ptr = (n < 2) ? {n[0], 21'h1fffff} : rnd[21:0];
            bus(1'b1, 8'h04, {26'h0, ptr[21:16]});
            bus(1'b1, 8'h08, {24'h0, ptr[15:8]});
            bus(1'b1, 8'h0c, {24'h0, ptr[7:0]});
            rnd = lfsr(rnd);
            latch = rnd[7:0];
            bus(1'b1, 8'h00, {24'h0, latch});
            rd(8'h14, {29'h0, ptr[21], 2'h0});
            for (m = 0; m < 4; m++) op(1'b1, m[1:0]);
            for (m = 0; m < 4; m++) op(1'b0, m[1:0]);
            // Timed write, erase, and both at once where erase wins
            c = 2'(n % 3 + 1);
            start_q.push_back({14'h0, c == 2'h1, c != 2'h1, ptr[21:6]});
            bus(1'b1, 8'h10, {30'h0, c});
            bus(1'b1, 8'h10, {30'h0, c}); // Array busy, so no second start
            rd(8'h14, {29'h0, ptr[21], 2'h2});
            for (m = 0; m < 50 && flash_busy !== 1'b0; m++) @(posedge clk_sys);
            if (flash_busy !== 1'b0) begin
                error_cnt++;
                report_and_stop();
            end
        end
        check("queues drained", 32'h0, 32'(rd_q.size() + hold_q.size() + start_q.size()));
        report_and_stop();
    end
endmodule : table_pointer_access_tb
